//--- logic/atbw_seq.sv
`timescale 1ns/1ps
`default_nettype none
module atbw_seq #(
    parameter int SAR_DIV = 4
) (
    input wire logic clk,
    input wire logic arst_n,
    atbw_if.seq c
);
    typedef enum logic [2:0] {S_IDLE, S_PWRUP, S_TRACK, S_TAIL, S_CONV} atbw_st_t;
    atbw_st_t st_q;
    logic [15:0] cnt_q;
    logic [$clog2(SAR_DIV)-1:0] div_q;
    logic sar_tick;
    logic start_ok;
    logic [15:0] pwr_cyc;
    logic [15:0] post_cyc;
    logic sleep_mode;

    assign sar_tick = (div_q == ($clog2(SAR_DIV))'(SAR_DIV - 1));
    // burst with enable clear: core sleeps between conversions
    assign sleep_mode = c.burst_en && !c.conv_en;
    assign start_ok = c.start && (c.conv_en || c.burst_en);
    // (R4) powerup length
    assign pwr_cyc = 16'((c.pwr + 5'd1) * atbw_pkg::PWR_UNIT_CYC);
    // (R6) sar cycles by code, counted in system clocks
    assign post_cyc = 16'((atbw_pkg::POST_TRACK_BASE << c.tk) * SAR_DIV);

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            div_q <= '0;
            c.sar_clk <= 1'b0;
        end else begin
            div_q <= sar_tick ? '0 : div_q + 1'b1;
            c.sar_clk <= (div_q < ($clog2(SAR_DIV))'(SAR_DIV / 2));
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            st_q <= S_IDLE;
            cnt_q <= '0;
            c.convert <= 1'b0;
        end else begin
            c.convert <= 1'b0;
            unique case (st_q)
                S_IDLE: begin
                    if (start_ok) begin
                        // (R3) wake on start
                        if (sleep_mode) begin
                            st_q <= S_PWRUP;
                            cnt_q <= pwr_cyc - 16'd1;
                        // (R5) pre-track converts at once
                        end else if (c.tm == atbw_pkg::TM_PRE) begin
                            st_q <= S_CONV;
                            c.convert <= 1'b1;
                        end else begin
                            st_q <= S_TRACK;
                            cnt_q <= post_cyc;
                        end
                    end
                end
                S_PWRUP: begin
                    // (R4) wait powerup
                    if (cnt_q == 16'd0) begin
                        if (c.tm == atbw_pkg::TM_PRE) begin
                            st_q <= S_CONV;
                            c.convert <= 1'b1;
                        end else begin
                            st_q <= S_TRACK;
                            cnt_q <= post_cyc;
                        end
                    end else begin
                        cnt_q <= cnt_q - 16'd1;
                    end
                end
                S_TRACK: begin
                    // (R6) whole sar periods in system clocks
                    // counting ticks would let a partial first period cut tracking short
                    if (cnt_q == 16'd1) begin
                        st_q <= S_TAIL;
                        cnt_q <= 16'(atbw_pkg::TAIL_SYSTEM_CLOCK_CYC - 1);
                    end else begin
                        cnt_q <= cnt_q - 16'd1;
                    end
                end
                S_TAIL: begin
                    // (R6) two system clocks
                    if (cnt_q == 16'd0) begin
                        st_q <= S_CONV;
                        c.convert <= 1'b1;
                    end else begin
                        cnt_q <= cnt_q - 16'd1;
                    end
                end
                S_CONV: begin
                    if (c.core_done) begin
                        st_q <= S_IDLE;
                    end
                end
                default: st_q <= S_IDLE;
            endcase
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            c.power_en <= 1'b0;
            c.track <= 1'b0;
            c.busy <= 1'b0;
        end else begin
            // (R1) (R2) (R3) power source
            if (!c.burst_en) begin
                c.power_en <= c.conv_en;
            end else if (c.conv_en) begin
                c.power_en <= 1'b1;
            end else begin
                c.power_en <= (st_q != S_IDLE) || start_ok;
            end
            // (R5) pre and dual track while idle
            c.track <= (st_q == S_TRACK) || (st_q == S_TAIL) ||
                       (st_q == S_IDLE && c.power_en && c.tm[1]);
            c.busy <= (st_q != S_IDLE);
        end
    end
endmodule // atbw_seq
`default_nettype wire

//--- logic/atbw_top.sv
// Operation
// (R1) Burst off: converter power follows the enable bit only.
// (R2) Burst on, enable set: converter stays powered between conversions.
// (R3) Burst on, enable clear: converter sleeps, wakes on each start.
// (R4) Wait (powerup field plus one) times 200 ns before converting.
// (R5) Tracking mode field: 01 post, 10 pre, 11 dual tracking.
// (R6) Post-track is 2,4,8,16 converter clocks plus two system clocks.
// (R7) Window detector compares every result against limits without software.
// (R8) Window hit sets flag in control register, usable as interrupt.
// (R9) Upper and lower limits each held as high and low byte registers.
// (R10) Flag means inside or outside, chosen by limit register contents.
// (R11) Lower above upper flags inside; otherwise flags outside the limits.
//
// Decided for this implementation: register access over AHB-Lite.
`timescale 1ns/1ps
`default_nettype none
module atbw_top #(
    parameter int RES_W = 16,
    parameter int SAR_DIV = 4
) (
    input wire logic REF_CLK,
    input wire logic ARST_N,
    input wire logic HSEL,
    input wire logic [31:0] HADDR,
    input wire logic [1:0] HTRANS,
    input wire logic HWRITE,
    input wire logic [2:0] HSIZE,
    input wire logic [31:0] HWDATA,
    input wire logic HREADY,
    output logic [31:0] HRDATA,
    output logic HREADYOUT,
    output logic HRESP,
    input wire logic CONV_START,
    input wire logic CORE_DONE,
    input wire logic [RES_W-1:0] CORE_RESULT,
    output logic CORE_POWER_EN,
    output logic CORE_TRACK,
    output logic CORE_CONVERT,
    output logic CORE_SAR_CLK,
    output logic IRQ
);
    atbw_if #(.RES_W(RES_W)) bus_if ();

    logic [7:0] track_q;
    logic [7:0] ctrl_q;
    logic [7:0] upper_hi_q;
    logic [7:0] upper_lo_q;
    logic [7:0] lower_hi_q;
    logic [7:0] lower_lo_q;
    logic [atbw_pkg::ST_W-1:0] stat_q;
    logic [atbw_pkg::ST_W-1:0] mask_q;
    logic [atbw_pkg::ST_W-1:0] stat_set;
    logic [atbw_pkg::ST_W-1:0] stat_clr;
    logic sw_start_q;
    logic addr_ok;
    logic wr_pend_q;
    logic rd_pend_q;
    logic [7:0] idx_q;
    logic [31:0] rd_d;
    logic [7:0] wbyte;
    logic [31:0] a_unused;
    logic [2:0] s_unused;

    assign addr_ok = HSEL && HREADY && (HTRANS == atbw_pkg::HTRANS_NONSEQ);
    assign wbyte = HWDATA[7:0];
    // only single word transfers; upper address and size carry nothing
    assign a_unused = HADDR;
    assign s_unused = HSIZE;

    always_ff @(posedge REF_CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            wr_pend_q <= 1'b0;
            rd_pend_q <= 1'b0;
            idx_q <= 8'h00;
        end else begin
            wr_pend_q <= addr_ok && HWRITE;
            rd_pend_q <= addr_ok && !HWRITE;
            if (addr_ok) begin
                idx_q <= HADDR[atbw_pkg::IDX_LSB +: 8];
            end
        end
    end

    // reads take one wait state so a write just ahead is already visible
    always_ff @(posedge REF_CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            HREADYOUT <= 1'b1;
            HRESP <= 1'b0;
            HRDATA <= 32'h00000000;
        end else begin
            HRESP <= 1'b0;
            if (addr_ok && !HWRITE) begin
                HREADYOUT <= 1'b0;
            end else if (rd_pend_q) begin
                HREADYOUT <= 1'b1;
                HRDATA <= rd_d;
            end
        end
    end

    always_comb begin
        rd_d = 32'h00000000;
        unique case (idx_q)
            atbw_pkg::IDX_TRACK: rd_d[7:0] = track_q;
            atbw_pkg::IDX_CTRL: begin
                rd_d[7:0] = ctrl_q;
                // (R8) flag visible for polling
                rd_d[atbw_pkg::CTRL_WIN_BIT] = stat_q[atbw_pkg::ST_WIN_BIT];
                rd_d[atbw_pkg::CTRL_BUSY_BIT] = bus_if.busy;
                rd_d[atbw_pkg::CTRL_START_BIT] = 1'b0;
            end
            atbw_pkg::IDX_STAT: rd_d[atbw_pkg::ST_W-1:0] = stat_q;
            atbw_pkg::IDX_MASK: rd_d[atbw_pkg::ST_W-1:0] = mask_q;
            atbw_pkg::IDX_UPPER_HI: rd_d[7:0] = upper_hi_q;
            atbw_pkg::IDX_UPPER_LO: rd_d[7:0] = upper_lo_q;
            atbw_pkg::IDX_LOWER_HI: rd_d[7:0] = lower_hi_q;
            atbw_pkg::IDX_LOWER_LO: rd_d[7:0] = lower_lo_q;
            default: rd_d = 32'h00000000;
        endcase
    end

    always_ff @(posedge REF_CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            track_q <= atbw_pkg::TRACK_RST;
            ctrl_q <= atbw_pkg::CTRL_RST;
            mask_q <= '0;
        end else if (wr_pend_q) begin
            unique case (idx_q)
                // (R4) (R5) (R6) timing fields
                atbw_pkg::IDX_TRACK: track_q <= wbyte;
                atbw_pkg::IDX_CTRL: begin
                    ctrl_q[atbw_pkg::CTRL_EN_BIT] <= wbyte[atbw_pkg::CTRL_EN_BIT];
                    ctrl_q[atbw_pkg::CTRL_BURST_BIT] <= wbyte[atbw_pkg::CTRL_BURST_BIT];
                end
                atbw_pkg::IDX_MASK: mask_q <= wbyte[atbw_pkg::ST_W-1:0];
                default: ;
            endcase
        end
    end

    // (R9) limit byte pairs
    always_ff @(posedge REF_CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            upper_hi_q <= atbw_pkg::LIMIT_RST;
            upper_lo_q <= atbw_pkg::LIMIT_RST;
            lower_hi_q <= atbw_pkg::LIMIT_RST;
            lower_lo_q <= atbw_pkg::LIMIT_RST;
        end else if (wr_pend_q) begin
            unique case (idx_q)
                atbw_pkg::IDX_UPPER_HI: upper_hi_q <= wbyte;
                atbw_pkg::IDX_UPPER_LO: upper_lo_q <= wbyte;
                atbw_pkg::IDX_LOWER_HI: lower_hi_q <= wbyte;
                atbw_pkg::IDX_LOWER_LO: lower_lo_q <= wbyte;
                default: ;
            endcase
        end
    end

    // software start is a one-cycle pulse, never stored
    always_ff @(posedge REF_CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            sw_start_q <= 1'b0;
        end else begin
            sw_start_q <= wr_pend_q && (idx_q == atbw_pkg::IDX_CTRL) &&
                          wbyte[atbw_pkg::CTRL_START_BIT];
        end
    end

    assign stat_set[atbw_pkg::ST_WIN_BIT] = bus_if.win_hit;
    assign stat_set[atbw_pkg::ST_DONE_BIT] = CORE_DONE;
    assign stat_clr = (wr_pend_q && (idx_q == atbw_pkg::IDX_STAT)) ?
                      wbyte[atbw_pkg::ST_W-1:0] : '0;

    // set wins over a same-cycle clear
    always_ff @(posedge REF_CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            stat_q <= '0;
            IRQ <= 1'b0;
        end else begin
            // (R8) window flag sticky
            stat_q <= (stat_q & ~stat_clr) | stat_set;
            IRQ <= |(((stat_q & ~stat_clr) | stat_set) & mask_q);
        end
    end

    assign bus_if.conv_en = ctrl_q[atbw_pkg::CTRL_EN_BIT];
    assign bus_if.burst_en = ctrl_q[atbw_pkg::CTRL_BURST_BIT];
    assign bus_if.pwr = track_q[atbw_pkg::PWR_MSB:atbw_pkg::PWR_LSB];
    assign bus_if.tm = track_q[atbw_pkg::TM_MSB:atbw_pkg::TM_LSB];
    assign bus_if.tk = track_q[atbw_pkg::TK_MSB:atbw_pkg::TK_LSB];
    assign bus_if.start = CONV_START || sw_start_q;
    assign bus_if.core_done = CORE_DONE;
    assign bus_if.result = CORE_RESULT;
    assign bus_if.upper = RES_W'({upper_hi_q, upper_lo_q});
    assign bus_if.lower = RES_W'({lower_hi_q, lower_lo_q});

    atbw_seq #(.SAR_DIV(SAR_DIV)) u_seq (
        .clk(REF_CLK),
        .arst_n(ARST_N),
        .c(bus_if)
    );

    // (R7) window compare
    atbw_win u_win (
        .clk(REF_CLK),
        .arst_n(ARST_N),
        .w(bus_if)
    );

    assign CORE_POWER_EN = bus_if.power_en;
    assign CORE_TRACK = bus_if.track;
    assign CORE_CONVERT = bus_if.convert;
    assign CORE_SAR_CLK = bus_if.sar_clk;
endmodule // atbw_top
`default_nettype wire

//--- logic/atbw_win.sv
`timescale 1ns/1ps
`default_nettype none
module atbw_win (
    input wire logic clk,
    input wire logic arst_n,
    atbw_if.win w
);
    logic inside_mode;
    logic hit;

    // (R10) (R11) mode from limit order
    assign inside_mode = (w.lower > w.upper);
    assign hit = inside_mode ? (w.result > w.upper && w.result < w.lower)
                             : (w.result < w.lower || w.result > w.upper);

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            w.win_hit <= 1'b0;
        end else begin
            // (R7) every new result compared
            w.win_hit <= w.core_done && hit;
        end
    end
endmodule // atbw_win
`default_nettype wire

//--- shared/atbw_if.sv
`timescale 1ns/1ps
`default_nettype none
interface atbw_if #(parameter int RES_W = 16);
    logic conv_en;
    logic burst_en;
    logic [3:0] pwr;
    logic [1:0] tm;
    logic [1:0] tk;
    logic start;
    logic core_done;
    logic busy;
    logic power_en;
    logic track;
    logic convert;
    logic sar_clk;
    logic [RES_W-1:0] result;
    logic [RES_W-1:0] upper;
    logic [RES_W-1:0] lower;
    logic win_hit;

    modport seq (input conv_en, burst_en, pwr, tm, tk, start, core_done,
                 output busy, power_en, track, convert, sar_clk);
    modport win (input core_done, result, upper, lower, output win_hit);
    modport top (output conv_en, burst_en, pwr, tm, tk, start, core_done, result, upper, lower,
                 input busy, power_en, track, convert, sar_clk, win_hit);
endinterface
`default_nettype wire

//--- shared/atbw_pkg.sv
package atbw_pkg;
    localparam int CLK_FREQ_MHZ = 200;
    localparam int PWR_UNIT_NS = 200;
    // least time, rounded up to whole cycles
    localparam int PWR_UNIT_CYC = (PWR_UNIT_NS * CLK_FREQ_MHZ + 999) / 1000;
    localparam int TAIL_SYSTEM_CLOCK_CYC = 2;
    localparam int POST_TRACK_BASE = 2;

    localparam logic [7:0] IDX_TRACK = 8'hBA;
    localparam logic [7:0] IDX_CTRL = 8'hB8;
    localparam logic [7:0] IDX_STAT = 8'hBB;
    localparam logic [7:0] IDX_MASK = 8'hBC;
    localparam logic [7:0] IDX_UPPER_LO = 8'hC3;
    localparam logic [7:0] IDX_UPPER_HI = 8'hC4;
    localparam logic [7:0] IDX_LOWER_LO = 8'hC5;
    localparam logic [7:0] IDX_LOWER_HI = 8'hC6;
    localparam int IDX_LSB = 2;

    localparam logic [7:0] TRACK_RST = 8'hFF;
    localparam logic [7:0] CTRL_RST = 8'h00;
    localparam logic [7:0] LIMIT_RST = 8'h00;
    localparam int PWR_MSB = 7;
    localparam int PWR_LSB = 4;
    localparam int TM_MSB = 3;
    localparam int TM_LSB = 2;
    localparam int TK_MSB = 1;
    localparam int TK_LSB = 0;

    localparam int CTRL_EN_BIT = 0;
    localparam int CTRL_BURST_BIT = 1;
    localparam int CTRL_WIN_BIT = 2;
    localparam int CTRL_START_BIT = 3;
    localparam int CTRL_BUSY_BIT = 4;

    localparam int ST_W = 2;
    localparam int ST_WIN_BIT = 0;
    localparam int ST_DONE_BIT = 1;

    localparam logic [1:0] TM_POST = 2'h1;
    localparam logic [1:0] TM_PRE = 2'h2;
    localparam logic [1:0] TM_DUAL = 2'h3;

    localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
endpackage

//--- tb/atbw_core_model.sv
`timescale 1ns/1ps
`default_nettype none
module atbw_core_model #(
    parameter int RES_W = 16,
    parameter int DLY = 6
) (
    input wire logic clk,
    input wire logic arst_n,
    input wire logic convert,
    input wire logic [RES_W-1:0] res_val,
    output logic done,
    output logic [RES_W-1:0] result
);
    int cnt_q;
    logic done_q;
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            cnt_q <= 0;
            done_q <= 1'b0;
        end else begin
            done_q <= (cnt_q == 1);
            if (convert)
                cnt_q <= DLY;
            else if (cnt_q != 0)
                cnt_q <= cnt_q - 1;
        end
    end
    assign done = done_q;
    // stale result is inverted so a late sample cannot match
    assign result = done_q ? res_val : ~res_val;
endmodule // atbw_core_model
`default_nettype wire

//--- tb/atbw_top_sva.sv
`timescale 1ns/1ps
`default_nettype none
module atbw_top_sva (
    input wire logic REF_CLK,
    input wire logic ARST_N,
    input wire logic HSEL,
    input wire logic [1:0] HTRANS,
    input wire logic HWRITE,
    input wire logic HREADY,
    input wire logic [31:0] HRDATA,
    input wire logic HREADYOUT,
    input wire logic HRESP,
    input wire logic CORE_POWER_EN,
    input wire logic CORE_CONVERT,
    input wire logic IRQ
);
    default clocking @(posedge REF_CLK); endclocking
    default disable iff (!ARST_N);
    logic req;
    assign req = HSEL && HREADY && HTRANS == atbw_pkg::HTRANS_NONSEQ;
    bus_okay_a: assert property (HRESP == 1'b0)
        else $error("bus response not okay");
    read_wait_a: assert property (req && !HWRITE |=> !HREADYOUT ##1 HREADYOUT)
        else $error("read data phase length wrong");
    write_nowait_a: assert property (req && HWRITE |=> HREADYOUT)
        else $error("write inserted wait state");
    rdata_upper_a: assert property (HRDATA[31:8] == 24'h000000)
        else $error("read data upper bits not zero");
    // read data only moves when a read completes
    rdata_hold_a: assert property (HREADYOUT && $past(HREADYOUT) |-> $stable(HRDATA))
        else $error("read data changed outside a read");
    conv_pulse_a: assert property (CORE_CONVERT |=> !CORE_CONVERT)
        else $error("convert pulse longer than one cycle");
    conv_powered_a: assert property (CORE_CONVERT |-> CORE_POWER_EN)
        else $error("convert while core unpowered");
    pwr_delay_a: assert property ($rose(CORE_POWER_EN) |-> !CORE_CONVERT [*8])
        else $error("convert too soon after power up");
    cover property (req && !HWRITE);
    cover property (CORE_CONVERT);
    cover property ($rose(IRQ));
endmodule // atbw_top_sva
bind atbw_top atbw_top_sva chk (.REF_CLK, .ARST_N, .HSEL, .HTRANS, .HWRITE, .HREADY, .HRDATA, .HREADYOUT,
    .HRESP, .CORE_POWER_EN, .CORE_CONVERT, .IRQ);
`default_nettype wire

//--- tb/test_adc_track_burst_window_ctrl.sv
`timescale 1ns/1ps
`default_nettype none
module test_adc_track_burst_window_ctrl;
    localparam int sar_div = 4;
    logic clk, rst_n, hsel, hwrite, cs, hready, hresp, done, pwr, trk, cnv, sclk, irq;
    logic [1:0] htrans;
    logic [31:0] haddr, hwdata, hrdata, rdat;
    logic [15:0] res, rval;
    int fail_count, checked, n_cnv, n_trk;
    // lower, upper, result, hit
    logic [48:0] win_tbl [6] = '{{16'h0100, 16'h0200, 16'h0050, 1'b1}, {16'h0100, 16'h0200, 16'h0100, 1'b0},
        {16'h0100, 16'h0200, 16'h0201, 1'b1}, {16'h0200, 16'h0100, 16'h0150, 1'b1},
        {16'h0200, 16'h0100, 16'h0100, 1'b0}, {16'h0200, 16'h0100, 16'h0300, 1'b0}};

    atbw_top #(.SAR_DIV(sar_div)) dut (.REF_CLK(clk), .ARST_N(rst_n), .HSEL(hsel), .HADDR(haddr),
        .HTRANS(htrans), .HWRITE(hwrite), .HSIZE(3'h2), .HWDATA(hwdata), .HREADY(hready), .HRDATA(hrdata),
        .HREADYOUT(hready), .HRESP(hresp), .CONV_START(cs), .CORE_DONE(done), .CORE_RESULT(res),
        .CORE_POWER_EN(pwr), .CORE_TRACK(trk), .CORE_CONVERT(cnv), .CORE_SAR_CLK(sclk), .IRQ(irq));
    atbw_core_model core (.clk(clk), .arst_n(rst_n), .convert(cnv), .res_val(rval), .done(done), .result(res));

    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end

    task automatic report_and_stop;
        if (fail_count == 0 && checked > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            fail_count++;
            $display("wrong value at %0t: got %h want %h", $time, got, exp);
        end
    endtask

    // power is registered behind the control register: settled two edges after the write
    task automatic pwr_chk(input logic e);
        @(posedge clk);
        @(negedge clk);
        cmp(32'(pwr), 32'(e));
        @(posedge clk);
    endtask

    task automatic tmo;
        fail_count++;
        $display("wrong value at %0t: wait ran out", $time);
        report_and_stop();
    endtask

    // hready is a register, so its level at the falling edge is what the next rising edge sees
    task automatic bus_wait;
        int i;
        for (i = 0; i < 50; i++) begin
            @(negedge clk);
            if (hready === 1'b1)
                break;
            @(posedge clk);
        end
        if (i == 50)
            tmo();
        rdat = hrdata;
        @(posedge clk);
    endtask

    task automatic xfer(input logic w, input logic [7:0] idx, input logic [7:0] d);
        hsel <= 1'b1;
        haddr <= {22'h000000, idx, 2'h0};
        htrans <= atbw_pkg::HTRANS_NONSEQ;
        hwrite <= w;
        bus_wait();
        htrans <= 2'h0;
        hwdata <= {24'h000000, d};
        bus_wait();
    endtask

    task automatic wr(input logic [7:0] idx, input logic [7:0] d);
        xfer(1'b1, idx, d);
    endtask

    task automatic rd_chk(input logic [7:0] idx, input logic [31:0] exp);
        xfer(1'b0, idx, 8'h00);
        cmp(rdat, exp);
    endtask

    task automatic conv(input logic sw, input logic [15:0] v);
        int i;
        rval <= v;
        n_cnv = 0;
        n_trk = 0;
        if (sw) begin
            wr(atbw_pkg::IDX_CTRL, 8'h0B);
        end else begin
            cs <= 1'b1;
            @(posedge clk);
            cs <= 1'b0;
        end
        for (i = 0; i < 1500; i++) begin
            @(negedge clk);
            if (done === 1'b1)
                break;
            if (n_cnv == 0 && cnv === 1'b1)
                n_cnv = i + 1;
            else if (n_cnv == 0 && trk === 1'b1)
                n_trk++;
        end
        if (i == 1500)
            tmo();
        repeat (6) @(posedge clk);
    endtask

    task automatic s_regs;
        logic [7:0] lim [4] = '{atbw_pkg::IDX_UPPER_LO, atbw_pkg::IDX_UPPER_HI, atbw_pkg::IDX_LOWER_LO,
            atbw_pkg::IDX_LOWER_HI};
        rd_chk(atbw_pkg::IDX_TRACK, 32'h000000FF);
        rd_chk(atbw_pkg::IDX_CTRL, 32'h00000000);
        rd_chk(atbw_pkg::IDX_STAT, 32'h00000000);
        rd_chk(atbw_pkg::IDX_MASK, 32'h00000000);
        wr(8'h10, 8'h55);
        rd_chk(8'h10, 32'h00000000);
        wr(atbw_pkg::IDX_CTRL, 8'h1C);
        rd_chk(atbw_pkg::IDX_CTRL, 32'h00000000);
        for (int i = 0; i < 4; i++) begin
            rd_chk(lim[i], 32'h00000000);
            wr(lim[i], 8'(8'h11 * (i + 1)));
            rd_chk(lim[i], 32'(8'h11 * (i + 1)));
        end
    endtask

    task automatic s_power;
        wr(atbw_pkg::IDX_TRACK, 8'h08);
        wr(atbw_pkg::IDX_CTRL, 8'h00);
        pwr_chk(1'b0);
        wr(atbw_pkg::IDX_CTRL, 8'h01);
        pwr_chk(1'b1);
        wr(atbw_pkg::IDX_TRACK, 8'hF8);
        pwr_chk(1'b1);
        wr(atbw_pkg::IDX_CTRL, 8'h03);
        conv(1'b1, 16'h0000);
        pwr_chk(1'b1);
        wr(atbw_pkg::IDX_CTRL, 8'h02);
        pwr_chk(1'b0);
        for (int p = 0; p < 16; p += 15) begin
            wr(atbw_pkg::IDX_TRACK, {4'(p), 4'h8});
            conv(1'b0, 16'h0000);
            cmp(32'(n_cnv >= (p + 1) * 40 && n_cnv <= (p + 1) * 40 + 5), 32'h1);
            pwr_chk(1'b0);
        end
    endtask

    task automatic s_track;
        int e;
        wr(atbw_pkg::IDX_CTRL, 8'h01);
        for (int m = 0; m < 4; m++) begin
            wr(atbw_pkg::IDX_TRACK, {4'h0, 2'(m), 2'h0});
            repeat (3) @(posedge clk);
            cmp(32'(trk), 32'(m >= 2));
        end
        // sar clock is high for half of each period
        e = 0;
        repeat (4 * sar_div) begin
            @(negedge clk);
            e += int'(sclk === 1'b1);
        end
        @(posedge clk);
        cmp(32'(e), 32'(2 * sar_div));
        for (int k = 0; k < 4; k++) begin
            e = (2 << k) * sar_div + 2;
            wr(atbw_pkg::IDX_TRACK, {4'h0, atbw_pkg::TM_POST, 2'(k)});
            conv(1'b0, 16'h0000);
            cmp(32'(n_trk >= e - 1 && n_trk <= e + 5), 32'h1);
        end
    endtask

    task automatic s_window;
        logic h;
        wr(atbw_pkg::IDX_MASK, 8'h01);
        wr(atbw_pkg::IDX_TRACK, 8'h04);
        for (int i = 0; i < 6; i++) begin
            h = win_tbl[i][0];
            wr(atbw_pkg::IDX_LOWER_HI, win_tbl[i][48:41]);
            wr(atbw_pkg::IDX_LOWER_LO, win_tbl[i][40:33]);
            wr(atbw_pkg::IDX_UPPER_HI, win_tbl[i][32:25]);
            wr(atbw_pkg::IDX_UPPER_LO, win_tbl[i][24:17]);
            conv(1'b0, win_tbl[i][16:1]);
            rd_chk(atbw_pkg::IDX_STAT, {30'h0, 1'b1, h});
            rd_chk(atbw_pkg::IDX_CTRL, {29'h0, h, 2'h1});
            cmp(32'(irq), 32'(h));
            wr(atbw_pkg::IDX_STAT, 8'h03);
            repeat (2) @(posedge clk);
            cmp(32'(irq), 32'h0);
            rd_chk(atbw_pkg::IDX_STAT, 32'h00000000);
        end
    endtask

    initial begin
        rst_n = 1'b0;
        hsel = 1'b0;
        haddr = 32'h0;
        htrans = 2'h0;
        hwrite = 1'b0;
        hwdata = 32'h0;
        cs = 1'b0;
        rval = 16'h0;
        fail_count = 0;
        checked = 0;
        repeat (3) @(posedge clk);
        rst_n <= 1'b1;
        s_regs();
        s_power();
        s_track();
        s_window();
        report_and_stop();
    end
endmodule // test_adc_track_burst_window_ctrl
`default_nettype wire
